// ---- hw/asfc_ctl.v ----
// asfc_ctl.v: special-function control for the arithmetic slices
// assumes: microsequencer drives function field and cyc_start each
// microcycle; slices act on slice_clock enable pulses
`timescale 1ns/1ns
`include "asfc_defines.vh"

module asfc_ctl #(
	parameter FW = `ASFC_FW
) (
	// clock and reset
	input wire ref_clk,
	input wire arst_n,
	// microsequencer side
	input wire cyc_start,
	input wire [FW-1:0] datapath_function_field,
	// datapath status
	input wire lower_bit0,
	input wire alu_carry,
	input wire alu_bit0,
	input wire alu_shift_bit,
	input wire alu_is_addsub,
	input wire alu_is_shift,
	// slice control
	output reg slice_clock,
	output reg double_pulse_enable,
	output reg special_active,
	output reg [1:0] write_src_sel,
	output reg upper_load,
	output reg upper_clear,
	output reg [2:0] lower_load_sel,
	output reg flag_drive,
	output reg write_bus_31,
	output reg write_bus_30,
	output reg mul_active,
	output reg mul_negative,
	output reg div_active,
	output reg div_negative,
	output reg remainder_assemble,
	output reg double_divide,
	output reg alu_subtract,
	output reg iteration_control_flag,
	// flags
	output reg carry_keep_flag,
	output reg shift_out_flag,
	output reg loop_flag
);

reg [1:0] next_src;
reg next_upload;
reg next_uclr;
reg [2:0] next_qsel;
reg next_flag_drv;
reg next_wb31;
reg next_wb30;
reg next_spec;
reg is_mul;
reg is_div;
reg is_quick;
reg is_neg;
reg is_rem;
reg is_ddiv;
reg is_aluf;
wire [FW-1:0] f;
wire pulse;

assign f = datapath_function_field;

////////////////////////////////////////////////////////////////////////
// slice clock generator, shared by control and all slices
asfc_pulse_gen #(
	.PHASES(`ASFC_PHASES)
) u_pulse (
	.ref_clk(ref_clk),
	.arst_n(arst_n),
	.cyc_start(cyc_start),
	.double_pulse_enable(double_pulse_enable),
	.slice_clock(pulse)
);

////////////////////////////////////////////////////////////////////////
// multiply and divide code decode
always @* begin
	is_mul = 1'b0;
	is_div = 1'b0;
	is_quick = 1'b0;
	is_neg = 1'b0;
	is_rem = 1'b0;
	is_ddiv = 1'b0;
	case (f)
	`ASFC_MUL_QP: begin
		is_mul = 1'b1;
		is_quick = 1'b1;
	end
	`ASFC_MUL_SP: is_mul = 1'b1;
	`ASFC_MUL_QN: begin
		is_mul = 1'b1;
		is_quick = 1'b1;
		is_neg = 1'b1;
	end
	`ASFC_MUL_SN: begin
		is_mul = 1'b1;
		is_neg = 1'b1;
	end
	`ASFC_DIV_QP: begin
		is_div = 1'b1;
		is_quick = 1'b1;
	end
	`ASFC_DIV_SP: is_div = 1'b1;
	`ASFC_DIV_QN: begin
		is_div = 1'b1;
		is_quick = 1'b1;
		is_neg = 1'b1;
	end
	`ASFC_DIV_SN: begin
		is_div = 1'b1;
		is_neg = 1'b1;
	end
	`ASFC_REM: begin
		is_div = 1'b1;
		is_rem = 1'b1;
	end
	`ASFC_DDIV_P: begin
		is_div = 1'b1;
		is_ddiv = 1'b1;
	end
	`ASFC_DDIV_N: begin
		is_div = 1'b1;
		is_ddiv = 1'b1;
		is_neg = 1'b1;
	end
	default: is_neg = 1'b0;
	endcase
end

////////////////////////////////////////////////////////////////////////
// routing, scratch and flag output decode
always @* begin
	next_src = `ASFC_SRC_READ_BUS;
	next_upload = 1'b0;
	next_uclr = 1'b0;
	next_qsel = `ASFC_QL_HOLD;
	next_flag_drv = 1'b0;
	next_wb31 = 1'b0;
	next_wb30 = 1'b0;
	next_spec = is_mul | is_div;
	is_aluf = 1'b0;
	if (f[6:0] == `ASFC_ROUTE_LO || f[6:0] == `ASFC_WBD_LO) begin
		next_spec = 1'b1;
		next_upload = f[4];
		case ({f[9:8], f[7]})
		3'h0: next_qsel = `ASFC_QL_MEMORY_SIDE_BUS;
		3'h1: begin
			next_src = `ASFC_SRC_QOLD;
			next_qsel = `ASFC_QL_MEMORY_SIDE_BUS;
		end
		3'h2: next_qsel = `ASFC_QL_XMBUS;
		3'h3: begin
			next_src = `ASFC_SRC_SCRATCH_BUS;
			next_qsel = `ASFC_QL_XMBUS;
		end
		3'h4: next_qsel = `ASFC_QL_UPPER;
		3'h5: begin
			next_src = `ASFC_SRC_QOLD;
			next_qsel = `ASFC_QL_UPPER;
		end
		3'h6: begin
			next_src = `ASFC_SRC_SCRATCH_BUS;
			next_qsel = `ASFC_QL_UPPER;
		end
		default: begin
			next_src = `ASFC_SRC_SCRATCH_BUS;
			next_qsel = `ASFC_QL_READ_BUS;
		end
		endcase
	end else if (f[9:2] == `ASFC_SCRATCH_BUS_T || f[9:2] == `ASFC_SCRATCH_BUS_N) begin
		next_spec = 1'b1;
		// true or inverted scratch bus
		next_src = f[4] ? `ASFC_SRC_SCRATCH_BUS : `ASFC_SRC_NSBUS;
		next_qsel = f[0] ? `ASFC_QL_WSRC : `ASFC_QL_HOLD;
		next_upload = f[1];
	end else if (f[9:2] == `ASFC_FLAG_LOOP) begin
		next_spec = 1'b1;
		next_flag_drv = 1'b1;
		next_wb30 = loop_flag;
		// showing the loop flag leaves it intact
		is_aluf = 1'b1;
		next_qsel = f[0] ? `ASFC_QL_ZERO : `ASFC_QL_HOLD;
		next_uclr = f[1];
	end else if (f[9:2] == `ASFC_FLAG_ALU) begin
		next_spec = 1'b1;
		is_aluf = 1'b1;
		next_flag_drv = 1'b1;
		next_wb31 = shift_out_flag;
		next_wb30 = carry_keep_flag;
		next_src = `ASFC_SRC_SCRATCH_BUS;
		next_qsel = f[0] ? `ASFC_QL_WSRC : `ASFC_QL_HOLD;
		next_upload = f[1];
	end
	// setup cycle of multiply
	if (is_mul && !loop_flag) begin
		next_qsel = `ASFC_QL_SHR;
		next_uclr = 1'b1;
	end
end

////////////////////////////////////////////////////////////////////////
// registered control outputs, reloaded on every rising ref_clk edge
always @(posedge ref_clk or negedge arst_n) begin
	if (!arst_n) begin
		slice_clock <= 1'b0;
		double_pulse_enable <= 1'b0;
		special_active <= 1'b0;
		write_src_sel <= `ASFC_SRC_READ_BUS;
		upper_load <= 1'b0;
		upper_clear <= 1'b0;
		lower_load_sel <= `ASFC_QL_HOLD;
		flag_drive <= 1'b0;
		write_bus_31 <= 1'b0;
		write_bus_30 <= 1'b0;
		mul_active <= 1'b0;
		mul_negative <= 1'b0;
		div_active <= 1'b0;
		div_negative <= 1'b0;
		remainder_assemble <= 1'b0;
		double_divide <= 1'b0;
		alu_subtract <= 1'b0;
	end else begin
		slice_clock <= pulse;
		double_pulse_enable <= is_quick;
		special_active <= next_spec;
		write_src_sel <= next_src;
		upper_load <= next_upload;
		upper_clear <= next_uclr;
		lower_load_sel <= next_qsel;
		flag_drive <= next_flag_drv;
		// iteration flag has no write bus path
		write_bus_31 <= next_wb31;
		write_bus_30 <= next_wb30;
		mul_active <= is_mul;
		mul_negative <= is_mul & is_neg;
		div_active <= is_div;
		div_negative <= is_div & is_neg;
		remainder_assemble <= is_rem;
		double_divide <= is_ddiv;
		// flag picks add or subtract on divide
		alu_subtract <= is_div & ~iteration_control_flag;
	end
end

////////////////////////////////////////////////////////////////////////
// flags update on each slice clock pulse
always @(posedge ref_clk or negedge arst_n) begin
	if (!arst_n) begin
		iteration_control_flag <= 1'b0;
		carry_keep_flag <= 1'b0;
		shift_out_flag <= 1'b0;
		loop_flag <= 1'b0;
	end else if (pulse) begin
		if (is_mul) begin
			loop_flag <= 1'b1;
			iteration_control_flag <= lower_bit0;
			if (!loop_flag)
				carry_keep_flag <= 1'b0;
			else begin
				carry_keep_flag <= alu_bit0;
				shift_out_flag <= alu_bit0;
			end
		end else if (is_div) begin
			loop_flag <= 1'b1;
			if (!is_rem && !is_ddiv) begin
				iteration_control_flag <= alu_carry ^ is_neg;
				shift_out_flag <= alu_shift_bit;
			end
		end else begin
			if (!is_aluf)
				loop_flag <= 1'b0;
			if (!next_spec && alu_is_addsub)
				carry_keep_flag <= alu_carry;
			if (!next_spec && alu_is_shift)
				shift_out_flag <= alu_shift_bit;
		end
	end
end

endmodule

// ---- hw/asfc_defines.vh ----
// asfc_defines.vh: constants for the special-function control block
// assumes: included by bare name from the design files
`ifndef ASFC_DEFINES_VH
`define ASFC_DEFINES_VH

// function field width
`define ASFC_FW 10
// routing group, low 7 bits 0x47, write-bus-disable 0x57
`define ASFC_ROUTE_LO 7'h47
`define ASFC_WBD_LO 7'h57
// scratch bus output and flag output groups
`define ASFC_SCRATCH_BUS_T 8'hdc
`define ASFC_SCRATCH_BUS_N 8'hd8
`define ASFC_FLAG_LOOP 8'hde
`define ASFC_FLAG_ALU 8'hdf
// multiply codes
`define ASFC_MUL_QP 10'h279
`define ASFC_MUL_SP 10'h27b
`define ASFC_MUL_QN 10'h269
`define ASFC_MUL_SN 10'h26b
// divide codes
`define ASFC_DIV_QP 10'h26c
`define ASFC_DIV_SP 10'h26e
`define ASFC_DIV_QN 10'h27c
`define ASFC_DIV_SN 10'h27e
`define ASFC_REM 10'h26a
`define ASFC_DDIV_P 10'h27f
`define ASFC_DDIV_N 10'h26f
// source and load selects
`define ASFC_SRC_READ_BUS 2'h0
`define ASFC_SRC_QOLD 2'h1
`define ASFC_SRC_SCRATCH_BUS 2'h2
`define ASFC_SRC_NSBUS 2'h3
`define ASFC_QL_HOLD 3'h0
`define ASFC_QL_MEMORY_SIDE_BUS 3'h1
`define ASFC_QL_XMBUS 3'h2
`define ASFC_QL_UPPER 3'h3
`define ASFC_QL_READ_BUS 3'h4
`define ASFC_QL_WSRC 3'h5
`define ASFC_QL_ZERO 3'h6
`define ASFC_QL_SHR 3'h7
// microcycle phases: two slice pulses fit one microcycle
`define ASFC_PHASES 2
`define ASFC_PH_W 1

`endif

// ---- hw/asfc_pulse_gen.v ----
// asfc_pulse_gen.v: slice clock enable generator
// assumes: ref_clk is the base clock, cyc_start marks each microcycle
`timescale 1ns/1ns
`include "asfc_defines.vh"

module asfc_pulse_gen #(
	parameter PHASES = `ASFC_PHASES
) (
	// clock and reset
	input wire ref_clk,
	input wire arst_n,
	// control
	input wire cyc_start,
	input wire double_pulse_enable,
	// output
	output reg slice_clock
);

reg [`ASFC_PH_W-1:0] phase;

////////////////////////////////////////////////////////////////////////
// phase count within a microcycle
always @(posedge ref_clk or negedge arst_n) begin
	if (!arst_n)
		phase <= {`ASFC_PH_W{1'b0}};
	else if (cyc_start)
		phase <= {`ASFC_PH_W{1'b0}};
	else if (phase != PHASES[`ASFC_PH_W-1:0] - 1'b1)
		phase <= phase + 1'b1;
end

// one pulse per cycle, second pulse when doubled
always @(posedge ref_clk or negedge arst_n) begin
	if (!arst_n)
		slice_clock <= 1'b0;
	else
		slice_clock <= cyc_start |
			(double_pulse_enable &&
			phase == {`ASFC_PH_W{1'b0}} && !cyc_start);
end

endmodule

// ---- testbench/asfc_ctl_assertions.sv ----
// asfc_ctl_assertions.sv: port timing checks for asfc_ctl
// assumes: bound into asfc_ctl, one clock domain
`timescale 1ns/1ns
module asfc_chk (
	// clock and reset
	input wire ref_clk,
	input wire arst_n,
	// microword and datapath
	input wire cyc_start,
	input wire [9:0] datapath_function_field,
	input wire lower_bit0,
	input wire alu_carry,
	input wire alu_bit0,
	// watched outputs
	input wire slice_clock,
	input wire double_pulse_enable,
	input wire flag_drive,
	input wire write_bus_31,
	input wire write_bus_30,
	input wire iteration_control_flag,
	input wire carry_keep_flag,
	input wire shift_out_flag,
	input wire loop_flag
);
	wire [9:0] f = datapath_function_field;
	// code classes
	wire mul = f == 10'h279 || f == 10'h27b || f == 10'h269 || f == 10'h26b;
	wire div = f == 10'h26c || f == 10'h26e || f == 10'h27c || f == 10'h27e;
	wire dq = alu_carry ^ f[4];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	sequence two_pulses;
		slice_clock ##1 slice_clock;
	endsequence
	// slice pulse and flag update land two edges after cyc_start
	pulse_one_a: assert property (cyc_start |=> ##1 slice_clock)
		else $error("slice pulse missing");
	pulse_two_a: assert property (cyc_start && double_pulse_enable
		|=> ##1 two_pulses) else $error("second pulse missing");
	mul_iter_a: assert property (mul && cyc_start
		|=> ##1 iteration_control_flag == $past(lower_bit0))
		else $error("mul flag");
	div_iter_a: assert property (div && cyc_start
		|=> ##1 iteration_control_flag == $past(dq)) else $error("div flag");
	keep_iter_a: assert property (mul && cyc_start && loop_flag
		|=> ##1 carry_keep_flag == $past(alu_bit0)) else $error("keep flag");
	loop_set_a: assert property ((mul || div) && cyc_start
		|=> ##1 loop_flag) else $error("loop not set");
	loop_out_a: assert property (f[9:2] == 8'hde |=> flag_drive &&
		!write_bus_31 && write_bus_30 == $past(loop_flag)) else $error("loop out");
	alu_out_a: assert property (f[9:2] == 8'hdf |=> flag_drive &&
		write_bus_31 == $past(shift_out_flag) &&
		write_bus_30 == $past(carry_keep_flag)) else $error("alu flags out");
endmodule
bind asfc_ctl asfc_chk chk (.*);

// ---- testbench/asfc_msq.sv ----
// asfc_msq.sv: microsequencer model, holds code and counts steps
// assumes: four ref_clk cycles per microcycle, driven on falling edges
`timescale 1ns/1ns
module asfc_msq (
	// clock and reset
	input wire ref_clk,
	input wire arst_n,
	// requests
	input wire go,
	input wire [9:0] code,
	input wire [3:0] steps,
	// microword side
	output reg cyc_start,
	output reg [9:0] datapath_function_field,
	output wire busy
);
	reg [3:0] left;
	reg [1:0] ph;
	assign busy = left != 4'h0;
	// one start pulse per microcycle, code set two cycles ahead
	always @(negedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cyc_start <= 1'b0;
			datapath_function_field <= 10'h000;
			left <= 4'h0;
			ph <= 2'h0;
		end else begin
			cyc_start <= busy && ph == 2'h1;
			ph <= busy ? ph + 2'h1 : 2'h0;
			if (go) begin
				datapath_function_field <= code;
				left <= steps;
			end else if (busy && ph == 2'h3) begin
				left <= left - 4'h1;
			end
		end
	end
endmodule

// ---- testbench/tb_top.sv ----
// tb_top.sv: self-checking bench for asfc_ctl
// assumes: asfc_msq feeds codes, checker bound to dut
`timescale 1ns/1ns
module tb_top;
	reg ref_clk = 1'b0;
	reg arst_n = 1'b0;
	reg go = 1'b0;
	reg lower_bit0 = 1'b0;
	reg alu_carry = 1'b0;
	reg alu_bit0 = 1'b0;
	reg [9:0] code = 10'h000;
	reg [3:0] steps = 4'h1;
	wire cyc_start, busy, slice_clock, double_pulse_enable, special_active;
	wire upper_load, upper_clear, flag_drive, write_bus_31, write_bus_30;
	wire mul_active, mul_negative, div_active, div_negative, double_divide;
	wire remainder_assemble, alu_subtract, iteration_control_flag;
	wire carry_keep_flag, shift_out_flag, loop_flag;
	wire [9:0] datapath_function_field;
	wire [1:0] write_src_sel;
	wire [2:0] lower_load_sel;
	integer errors = 0, total_checks = 0, pulses = 0, i;
	integer pulse_base = 0;
	localparam [15:0] route_src = 16'ha484;
	localparam [23:0] route_lq = 24'h8db489;
	//////////////////////////////////////////
	always #20 ref_clk = ~ref_clk;
	// slice pulses counted since the start of the run
	always @(posedge ref_clk) if (slice_clock === 1'b1) pulses <= pulses + 1;
	asfc_ctl dut (.*, .alu_shift_bit(1'b0), .alu_is_addsub(1'b0),
		.alu_is_shift(1'b0));
	asfc_msq msq (.*);
	//////////////////////////////////////////
	task chk(input [47:0] name, input [9:0] got, input [9:0] exp);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("[FAIL] %0s exp %h got %h", name, exp, got);
			end
		end
	endtask
	task stop_test;
		begin
			$display("checks %0d mismatches %0d", total_checks, errors);
			if (errors == 0 && total_checks > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	// run n microcycles of code c, wait bounded for the end
	task op(input [9:0] c, input [3:0] n);
		integer k;
		begin
			go <= 1'b1;
			code <= c;
			steps <= n;
			pulse_base = pulses;
			@(negedge ref_clk);
			go <= 1'b0;
			for (k = 0; k < 40 && (k < 2 || busy); k = k + 1)
				@(negedge ref_clk);
			// let the last slice pulses of the operation land
			repeat (2) @(negedge ref_clk);
			if (busy) begin
				errors = errors + 1;
				stop_test;
			end
		end
	endtask
	//////////////////////////////////////////
	initial begin
		repeat (8) @(negedge ref_clk);
		arst_n <= 1'b1;
		@(negedge ref_clk);
		for (i = 0; i < 16; i = i + 1) begin
			op({i[2:0], i[3] ? 7'h57 : 7'h47}, 4'h1);
			chk("src", write_src_sel, route_src[2 * (i % 8) +: 2]);
			chk("lq", lower_load_sel, route_lq[3 * (i % 8) +: 3]);
			chk("dload", upper_load, i / 8);
			chk("spec", special_active, 1);
		end
		$display("routing done");
		for (i = 0; i < 8; i = i + 1) begin
			op(10'h360 + i % 4 + (i / 4) * 16, 4'h1);
			chk("src", write_src_sel, 3 - i / 4);
			chk("lq", lower_load_sel, (i % 2) * 5);
			chk("dload", upper_load, (i / 2) % 2);
		end
		$display("scratch done");
		op(10'h27b, 4'h1);
		for (i = 0; i < 8; i = i + 1) begin
			op(10'h378 + i, 4'h1);
			chk("loop", loop_flag, 1);
			chk("lq", lower_load_sel != 3'h0, i % 2);
			chk("d", i < 4 ? upper_clear : upper_load, (i / 2) % 2);
			chk("fdrv", flag_drive, 1);
			chk("wb30", write_bus_30, i < 4);
			chk("wb31", write_bus_31, 0);
		end
		$display("flags done");
		op(10'h000, 4'h1);
		chk("loop", loop_flag, 0);
		lower_bit0 = 1'b1;
		alu_bit0 = 1'b1;
		op(10'h27b, 4'h1);
		chk("loop", loop_flag, 1);
		chk("iter", iteration_control_flag, 1);
		chk("keep", carry_keep_flag, 0);
		chk("pulses", pulses - pulse_base, 1);
		lower_bit0 = 1'b0;
		op(10'h27b, 4'h2);
		chk("iter", iteration_control_flag, 0);
		chk("keep", carry_keep_flag, 1);
		chk("mul", mul_active, 1);
		op(10'h269, 4'h3);
		chk("pulses", pulses - pulse_base, 6);
		chk("mneg", mul_negative, 1);
		$display("multiply done");
		alu_carry = 1'b1;
		for (i = 0; i < 4; i = i + 1) begin
			op(10'h26c + (i % 2) * 2 + (i / 2) * 16, 4'h1);
			chk("iter", iteration_control_flag, 1 - i / 2);
			chk("pulses", pulses - pulse_base, 2 - i % 2);
			chk("dneg", div_negative, i / 2);
			chk("sub", alu_subtract, i / 2);
			chk("dpe", double_pulse_enable, 1 - i % 2);
			chk("div", div_active, 1);
			chk("loop", loop_flag, 1);
		end
		op(10'h26a, 4'h1);
		chk("rem", remainder_assemble, 1);
		op(10'h27f, 4'h1);
		chk("ddiv", double_divide, 1);
		$display("divide done");
		stop_test;
	end
endmodule
